/* rtl/twt_pkg.sv */
/*
  Package of the two-wire target: register offsets, field positions,
  reset values, state codes and the packed state record.
  Assumes a 12-bit byte address on the register port, 32-bit data.
*/
package twt_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_STOP = 12'h014;
  localparam logic [11:0] OFS_SUSPEND = 12'h01C;
  localparam logic [11:0] OFS_RESUME = 12'h020;
  localparam logic [11:0] OFS_ARM = 12'h030;
  localparam logic [11:0] OFS_EV_STOPPED = 12'h104;
  localparam logic [11:0] OFS_EV_ERROR = 12'h124;
  localparam logic [11:0] OFS_EV_BEGUN = 12'h14C;
  localparam logic [11:0] OFS_EV_WRITE = 12'h164;
  localparam logic [11:0] OFS_EV_READ = 12'h168;
  localparam logic [11:0] OFS_SHORTS = 12'h200;
  localparam logic [11:0] OFS_MATCH = 12'h4D4;
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_PSEL_CLK = 12'h508;
  localparam logic [11:0] OFS_PSEL_DAT = 12'h50C;
  localparam logic [11:0] OFS_PTR = 12'h534;
  localparam logic [11:0] OFS_LIMIT = 12'h538;
  localparam logic [11:0] OFS_COUNT = 12'h53C;
  localparam logic [11:0] OFS_ADDR0 = 12'h588;
  localparam logic [11:0] OFS_ADDR1 = 12'h58C;
  localparam logic [11:0] OFS_CONFIG = 12'h594;
  // Field positions
  localparam int SHORT_READ_SUSPEND_BIT = 0;
  localparam int ENABLE_BIT = 0;
  localparam int TRIGGER_BIT = 0;
  // Widths
  localparam int NPINS = 8;
  localparam int PSEL_W = 3;
  localparam int LIM_W = 16;
  localparam int TADR_W = 7;
  // Reset values, and the number of bits in a byte
  localparam logic [TADR_W-1:0] TADR_RST = 7'h00;
  localparam logic [1:0] CONFIG_RST = 2'h1;
  localparam logic [PSEL_W-1:0] PSEL_CLK_RST = 3'h0;
  localparam logic [PSEL_W-1:0] PSEL_DAT_RST = 3'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Bus engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WAIT = 3'b010,
    ST_ACK = 3'b011,
    ST_RX = 3'b100,
    ST_SKIP = 3'b101
  } twt_state_t;

  // DMA write strobe with its data
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] data;
  } twt_dma_t;

  // Whole state of the target
  typedef struct packed {
    twt_state_t st;
    logic en;
    logic armed;
    logic susp;
    logic stop_req;
    logic short_rd;
    logic [1:0] cfg;
    logic [TADR_W-1:0] adr0;
    logic [TADR_W-1:0] adr1;
    logic [PSEL_W-1:0] psel_c;
    logic [PSEL_W-1:0] psel_d;
    logic [31:0] ptr;
    logic [31:0] ptr_l;
    logic [LIM_W-1:0] lim;
    logic [LIM_W-1:0] lim_l;
    logic [LIM_W-1:0] amount;
    logic match;
    logic [7:0] shr;
    logic [3:0] bitc;
    logic ev_stop;
    logic ev_err;
    logic ev_begun;
    logic ev_wr;
    logic ev_rd;
    logic scl_p;
    logic sda_p;
    logic scl_oe;
    logic sda_oe;
    logic [31:0] rdata;
    twt_dma_t dma;
    logic [NPINS-1:0] pad_o;
    logic [NPINS-1:0] pad_oe;
  } twt_state_rec_t;
endpackage

/* rtl/twt_sync.sv */
/*
  Two-flop synchroniser for a vector of pad levels.
  Assumes each bit is an independent level from outside the clock domain.
*/
`timescale 1ns/1ps
module twt_sync #(
  parameter int W = 8
) (
  input wire logic clock, // System clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [W-1:0] d, // Raw levels
  output logic [W-1:0] q // Synchronised levels
);
  logic [W-1:0] meta_r; // First stage, read only by the second

  // Two stages; pads idle high, so reset to ones avoids a false start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // twt_sync

/* rtl/twt_target.sv */
/*
  Two-wire target that answers master write commands and stores the
  received bytes through a DMA write port, with tasks, events and pin
  selection reached over a plain register port.
  Assumes the DMA port accepts one byte every cycle without waiting and
  that the pads carry open-drain wires with pull-ups outside.
*/
// Behaviour
// - Start, address, direction zero is write
// - Compare against two configurable addresses
// - Acknowledge matches only, raise write event
// - New commands detected from idle, receive or skip
// - Arm task sets hidden armed flag
// - Armed write command enters receive state
// - Not armed: hold clock low until armed
// - Entering receive: begun event, disarm
// - Repeated start in receive begins a new address phase
// - Stop condition: halted event, disarm, idle
// - Bytes past limit dropped, refused, error
// - Pointer and limit latched at begun
// - Stop task halts, event, disarm, idle
// - Forced halt releases lines, always signals
// - Acknowledge bytes within limit, count them
// - Suspend holds clock low until resume
// - Shortcut: read event triggers suspend
// - Pin selections apply only while enabled
// - Enabled block starts idle, ready
`timescale 1ns/1ps
module twt_target
  import twt_pkg::*;
(
  input wire logic clock, // System clock, 100 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [11:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after the strobe
  output twt_dma_t dma_out, // DMA byte write
  input wire logic [NPINS-1:0] gpio_out, // Plain port output levels
  input wire logic [NPINS-1:0] gpio_oe, // Plain port output enables
  input wire logic [NPINS-1:0] pad_in, // Pad levels
  output logic [NPINS-1:0] pad_out, // Pad output levels
  output logic [NPINS-1:0] pad_oe // Pad output enables
);
  twt_state_rec_t s_r; // Registered state
  twt_state_rec_t s_nxt; // Next state
  logic [NPINS-1:0] pad_s; // Synchronised pad levels
  logic scl_s; // Selected clock line
  logic sda_s; // Selected data line
  logic start_c; // Start or repeated start seen
  logic stop_c; // Stop seen
  logic scl_rise; // Clock line rose
  logic scl_fall; // Clock line fell
  logic hit0; // Address 0 matches
  logic hit1; // Address 1 matches
  logic trig; // Written word triggers a task

  // All pads pass two flops before anything looks at them
  twt_sync #(.W(NPINS)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(pad_in),
    .q(pad_s)
  );

  // Line selection, conditions and address compare
  always_comb begin
    scl_s = pad_s[s_r.psel_c];
    sda_s = pad_s[s_r.psel_d];
    // Data moving while the clock is high marks a condition
    start_c = scl_s && s_r.scl_p && s_r.sda_p && !sda_s;
    stop_c = scl_s && s_r.scl_p && !s_r.sda_p && sda_s;
    scl_rise = scl_s && !s_r.scl_p;
    scl_fall = !scl_s && s_r.scl_p;
    // Both addresses are checked at once, each gated by its enable
    hit0 = s_r.cfg[0] && (s_r.shr[7:1] == s_r.adr0);
    hit1 = s_r.cfg[1] && (s_r.shr[7:1] == s_r.adr1);
    trig = reg_wdata[TRIGGER_BIT];
  end

  // Next-state logic: register port, then bus engine, then tasks
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_p = scl_s;
    s_nxt.sda_p = sda_s;
    s_nxt.rdata = 32'h0000_0000;
    s_nxt.dma.we = 1'b0;

    // Configuration writes and event clears
    if (reg_wr) begin
      case (reg_addr)
        OFS_EV_STOPPED: s_nxt.ev_stop = reg_wdata[0];
        OFS_EV_ERROR: s_nxt.ev_err = reg_wdata[0];
        OFS_EV_BEGUN: s_nxt.ev_begun = reg_wdata[0];
        OFS_EV_WRITE: s_nxt.ev_wr = reg_wdata[0];
        OFS_EV_READ: s_nxt.ev_rd = reg_wdata[0];
        OFS_SHORTS: s_nxt.short_rd = reg_wdata[SHORT_READ_SUSPEND_BIT];
        OFS_ENABLE: s_nxt.en = reg_wdata[ENABLE_BIT];
        // Pin choice is taken as written; changing it live is unsafe
        OFS_PSEL_CLK: s_nxt.psel_c = reg_wdata[PSEL_W-1:0];
        OFS_PSEL_DAT: s_nxt.psel_d = reg_wdata[PSEL_W-1:0];
        OFS_PTR: s_nxt.ptr = reg_wdata;
        OFS_LIMIT: s_nxt.lim = reg_wdata[LIM_W-1:0];
        OFS_ADDR0: s_nxt.adr0 = reg_wdata[TADR_W-1:0];
        OFS_ADDR1: s_nxt.adr1 = reg_wdata[TADR_W-1:0];
        OFS_CONFIG: s_nxt.cfg = reg_wdata[1:0];
        default: begin
          // Tasks are handled elsewhere; unmapped addresses are ignored
        end
      endcase
    end

    // Read path, one cycle late; unmapped reads return zero
    if (reg_rd) begin
      case (reg_addr)
        OFS_EV_STOPPED: s_nxt.rdata = {31'h0, s_r.ev_stop};
        OFS_EV_ERROR: s_nxt.rdata = {31'h0, s_r.ev_err};
        OFS_EV_BEGUN: s_nxt.rdata = {31'h0, s_r.ev_begun};
        OFS_EV_WRITE: s_nxt.rdata = {31'h0, s_r.ev_wr};
        OFS_EV_READ: s_nxt.rdata = {31'h0, s_r.ev_rd};
        OFS_SHORTS: s_nxt.rdata = {31'h0, s_r.short_rd};
        OFS_MATCH: s_nxt.rdata = {31'h0, s_r.match};
        OFS_ENABLE: s_nxt.rdata = {31'h0, s_r.en};
        OFS_PSEL_CLK: s_nxt.rdata = {29'h0, s_r.psel_c};
        OFS_PSEL_DAT: s_nxt.rdata = {29'h0, s_r.psel_d};
        OFS_PTR: s_nxt.rdata = s_r.ptr;
        OFS_LIMIT: s_nxt.rdata = {16'h0, s_r.lim};
        OFS_COUNT: s_nxt.rdata = {16'h0, s_r.amount};
        OFS_ADDR0: s_nxt.rdata = {25'h0, s_r.adr0};
        OFS_ADDR1: s_nxt.rdata = {25'h0, s_r.adr1};
        OFS_CONFIG: s_nxt.rdata = {30'h0, s_r.cfg};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Bus engine
    if (!s_r.en) begin
      // Disabled: engine parked idle with both lines released
      s_nxt.st = ST_IDLE;
      s_nxt.scl_oe = 1'b0;
      s_nxt.sda_oe = 1'b0;
    end else if (s_r.stop_req) begin
      // Forced halt wins over anything on the bus
      s_nxt.st = ST_IDLE;
      s_nxt.armed = 1'b0;
      s_nxt.susp = 1'b0;
      s_nxt.stop_req = 1'b0;
      s_nxt.scl_oe = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.ev_stop = 1'b1;
    end else if (stop_c) begin
      // Stop ends any transaction in progress
      if (s_r.st != ST_IDLE) begin
        s_nxt.ev_stop = 1'b1;
        s_nxt.armed = 1'b0;
      end
      s_nxt.st = ST_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else if (start_c) begin
      // A repeated start in receive or skip goes straight to a fresh
      // address phase, as a start from idle does
      if (s_r.st == ST_IDLE || s_r.st == ST_RX || s_r.st == ST_SKIP) begin
        s_nxt.st = ST_ADDR;
        s_nxt.bitc = 4'h0;
        s_nxt.sda_oe = 1'b0;
      end
    end else begin
      case (s_r.st)
        ST_IDLE: begin
          // Waits for a start condition
          s_nxt.sda_oe = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            s_nxt.shr = {s_r.shr[6:0], sda_s};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (scl_fall && s_r.bitc == BITS_PER_BYTE) begin
            if (hit0 || hit1) begin
              s_nxt.match = hit1 && !hit0;
              if (!s_r.shr[0]) begin
                // Write command taken; acknowledge may wait for arming
                s_nxt.ev_wr = 1'b1;
                if (s_r.armed) begin
                  s_nxt.st = ST_ACK;
                  s_nxt.sda_oe = 1'b1;
                  s_nxt.ev_begun = 1'b1;
                  s_nxt.armed = 1'b0;
                  s_nxt.ptr_l = s_r.ptr;
                  s_nxt.lim_l = s_r.lim;
                  s_nxt.amount = '0;
                end else begin
                  s_nxt.st = ST_WAIT;
                end
              end else begin
                // Read responses belong to another engine
                s_nxt.ev_rd = 1'b1;
                if (s_r.short_rd) begin
                  s_nxt.susp = 1'b1;
                end
                s_nxt.st = ST_SKIP;
              end
            end else begin
              // Not ours: answer nothing so the master sees a refusal
              s_nxt.st = ST_SKIP;
            end
          end
        end
        ST_WAIT: begin
          // Clock is held below; release it together with the acknowledge
          if (s_r.armed) begin
            s_nxt.st = ST_ACK;
            s_nxt.sda_oe = 1'b1;
            s_nxt.ev_begun = 1'b1;
            s_nxt.armed = 1'b0;
            s_nxt.ptr_l = s_r.ptr;
            s_nxt.lim_l = s_r.lim;
            s_nxt.amount = '0;
          end
        end
        ST_ACK: begin
          // Acknowledge bit ends on the next falling clock
          if (scl_fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.bitc = 4'h0;
            s_nxt.st = ST_RX;
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            s_nxt.shr = {s_r.shr[6:0], sda_s};
            s_nxt.bitc = s_r.bitc + 4'h1;
          end else if (scl_fall && s_r.bitc == BITS_PER_BYTE) begin
            s_nxt.st = ST_ACK;
            if (s_r.amount < s_r.lim_l) begin
              // Room left: store and acknowledge
              s_nxt.dma.we = 1'b1;
              s_nxt.dma.addr = s_r.ptr_l + {16'h0, s_r.amount};
              s_nxt.dma.data = s_r.shr;
              s_nxt.amount = s_r.amount + 16'h1;
              s_nxt.sda_oe = 1'b1;
            end else begin
              // Buffer full: byte dropped, data line left high
              s_nxt.sda_oe = 1'b0;
              s_nxt.ev_err = 1'b1;
            end
          end
        end
        ST_SKIP: begin
          // Ignores the bus until a stop or a new start
          s_nxt.sda_oe = 1'b0;
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end

    // Clock hold: waiting for arming, or suspended once the clock is low
    s_nxt.scl_oe = s_r.en && !s_r.stop_req &&
                   ((s_nxt.st == ST_WAIT) ||
                    (s_nxt.susp && (!scl_s || s_r.scl_oe)));

    // Tasks come last so that a trigger beats a clear in the same cycle
    if (reg_wr && trig) begin
      case (reg_addr)
        OFS_ARM: s_nxt.armed = 1'b1;
        OFS_STOP: s_nxt.stop_req = 1'b1;
        OFS_SUSPEND: s_nxt.susp = 1'b1;
        OFS_RESUME: s_nxt.susp = 1'b0;
        default: begin
          // Not a task
        end
      endcase
    end

    // Pads: selected pins follow the engine only while enabled
    for (int i = 0; i < NPINS; i++) begin
      if (s_r.en && s_r.psel_c == PSEL_W'(i)) begin
        s_nxt.pad_o[i] = 1'b0;
        s_nxt.pad_oe[i] = s_nxt.scl_oe;
      end else if (s_r.en && s_r.psel_d == PSEL_W'(i)) begin
        s_nxt.pad_o[i] = 1'b0;
        s_nxt.pad_oe[i] = s_nxt.sda_oe;
      end else begin
        s_nxt.pad_o[i] = gpio_out[i];
        s_nxt.pad_oe[i] = gpio_oe[i];
      end
    end
  end

  // One register for the whole state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cfg <= CONFIG_RST;
      s_r.adr0 <= TADR_RST;
      s_r.adr1 <= TADR_RST;
      s_r.psel_c <= PSEL_CLK_RST;
      s_r.psel_d <= PSEL_DAT_RST;
      s_r.scl_p <= 1'b1;
      s_r.sda_p <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = s_r.rdata;
  assign dma_out = s_r.dma;
  assign pad_out = s_r.pad_o;
  assign pad_oe = s_r.pad_oe;
endmodule // twt_target

/* verification/twt_bus_master.sv */
/*
  Behavioural two-wire bus master that drives the target's bus pins.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module twt_bus_master (
  input wire logic scl, // Resolved clock wire
  input wire logic sda, // Resolved data wire
  output logic scl_oe, // High pulls clock low
  output logic sda_oe // High pulls data low
);
  localparam realtime H = 62.5; // Half of the 125 ns bus clock
  localparam realtime Q = 31.25; // Data moves in mid low phase
  // Both lines released, clock stands still between frames
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Honour stretching; bounded so a stuck clock cannot hang the run
  task automatic hi();
    for (int n = 0; n < 4000 && scl !== 1'b1; n++) #10;
  endtask
  // Data falls while the clock is high
  task automatic start();
    sda_oe = 1'b1;
    #H scl_oe = 1'b1;
  endtask
  // Restart from a low clock
  task automatic rstart();
    #Q sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    hi();
    #Q sda_oe = 1'b1;
    #Q scl_oe = 1'b1;
  endtask
  // Data rises while the clock is high, lines left released
  task automatic stop();
    #Q sda_oe = 1'b1;
    #Q scl_oe = 1'b0;
    hi();
    #Q sda_oe = 1'b0;
    #H;
  endtask
  // Eight bits MSB first, then the target's answer (0 taken)
  task automatic xfer(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q sda_oe = ~b[i];
      #Q scl_oe = 1'b0;
      hi();
      #H scl_oe = 1'b1;
    end
    #Q sda_oe = 1'b0;
    #Q scl_oe = 1'b0;
    hi();
    ack = sda;
    #H scl_oe = 1'b1;
  endtask
endmodule // twt_bus_master

/* verification/twt_target_sva.sv */
/*
  Port checks of the two-wire target.
  Assumes it is bound to the target and sees only its ports.
*/
`timescale 1ns/1ps
module twt_target_sva
  import twt_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic sys_rst, // Reset, active high
  input wire logic [11:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire twt_dma_t dma_out, // Byte store
  input wire logic [NPINS-1:0] gpio_out, // Plain levels
  input wire logic [NPINS-1:0] gpio_oe, // Plain enables
  input wire logic [NPINS-1:0] pad_in, // Pad levels
  input wire logic [NPINS-1:0] pad_out, // Pad drive
  input wire logic [NPINS-1:0] pad_oe // Pad enables
);
  logic en_r; // Mirrored enable
  logic [PSEL_W-1:0] pc_r; // Mirrored clock pin
  logic [PSEL_W-1:0] pd_r; // Mirrored data pin
  logic stop_w; // Stop task written now
  assign stop_w = reg_wr && reg_addr == OFS_STOP && reg_wdata[TRIGGER_BIT];
  // Mirror settings so the bus pins can be located
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= 1'b0;
      pc_r <= PSEL_CLK_RST;
      pd_r <= PSEL_DAT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_ENABLE: en_r <= reg_wdata[ENABLE_BIT];
        OFS_PSEL_CLK: pc_r <= reg_wdata[PSEL_W-1:0];
        OFS_PSEL_DAT: pd_r <= reg_wdata[PSEL_W-1:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside a read answer");
  AST_EN_READBACK: assert property ($past(reg_rd) && $past(reg_addr) == OFS_ENABLE |->
    reg_rdata == {31'h0, $past(en_r)}) else $error("enable readback wrong");
  AST_DMA_PULSE: assert property (dma_out.we |=> !dma_out.we)
    else $error("store strobe longer than one cycle");
  AST_DMA_ENABLED: assert property (dma_out.we |-> en_r)
    else $error("store while disabled");
  AST_DMA_ACK: assert property (dma_out.we |-> ##[0:2] pad_oe[pd_r])
    else $error("stored byte not acknowledged");
  AST_GPIO_PASS: assert property (!$past(sys_rst) && !$past(en_r) |->
    pad_oe == $past(gpio_oe) && pad_out == $past(gpio_out)) else $error("pads not plain");
  AST_BUS_LOW: assert property (!$past(sys_rst) && $past(en_r) |->
    !pad_out[pc_r] && !pad_out[pd_r]) else $error("bus pin driven high");
  AST_STOP_RELEASE: assert property (stop_w && en_r |->
    ##[1:3] !pad_oe[pc_r] && !pad_oe[pd_r]) else $error("lines held after stop");
  COV_BYTE: cover property (dma_out.we);
  COV_HOLD: cover property (en_r && pad_oe[pc_r]);
  COV_STOP: cover property (stop_w && en_r);
endmodule // twt_target_sva
bind twt_target twt_target_sva u_sva (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dma_out(dma_out), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe));

/* verification/twt_target_tb_top.sv */
/*
  Self-checking bench of the two-wire target with a bus master model.
  Assumes pull-ups on both wires and default pins 0 (clock), 1 (data).
*/
`timescale 1ns/1ps
module twt_target_tb_top;
  import twt_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd; // Clock, reset, strobes
  logic [11:0] reg_addr; // Register address
  logic [31:0] reg_wdata, reg_rdata, rv, seed; // Data, read value, random state
  twt_dma_t dma_out; // Stored bytes
  logic [NPINS-1:0] gpio_out, gpio_oe, pad_out, pad_oe, pad_in; // Pads
  logic m_scl, m_sda, scl, sda, ack; // Master pulls, wires, answer bit
  logic [6:0] a0, a1; // Target addresses
  logic [7:0] bt[6]; // Payload bytes
  int n_fail, tests_run, ptr; // Counters, model buffer pointer
  int exp_a[$], exp_d[$]; // Model of the stored bytes
  logic [11:0] da[5] = '{OFS_CONFIG, OFS_PSEL_CLK, OFS_PSEL_DAT, OFS_STOP, 12'h7F0};
  logic [31:0] dv[5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0};
  // Open drain: any pull wins over the pull-up
  assign scl = ~(pad_oe[0] | m_scl);
  assign sda = ~(pad_oe[1] | m_sda);
  assign pad_in = {pad_out[7:2] | ~pad_oe[7:2], sda, scl};
  twt_target dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_out(dma_out), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe));
  twt_bus_master m (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(n, reg_rdata, e);
  endtask
  // Event read, compared, then cleared
  task automatic ev(input logic [11:0] a, input logic [31:0] e);
    rd(a, e, "event");
    wr(a, 32'h0);
  endtask
  // Model: a taken byte lands at the next buffer place
  task automatic sendb(input logic [7:0] b, input logic take);
    if (take) begin
      exp_a.push_back(ptr++);
      exp_d.push_back(b);
    end
    m.xfer(b, ack);
    chk("byte_ack", 32'(ack), 32'(!take));
  endtask
  // Wait for a clock hold, check it stands, then free it by a write
  task automatic held(input logic [11:0] a);
    for (int n = 0; n < 400 && pad_oe[0] !== 1'b1; n++) @(posedge clock);
    repeat (20) @(posedge clock);
    chk("clock_held", 32'(scl), 32'h0);
    wr(a, 32'h1);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Every store is compared with the model
  always @(posedge clock) begin
    if (dma_out.we === 1'b1) begin
      chk("dma_addr", dma_out.addr, exp_a.size() ? exp_a.pop_front() : -1);
      chk("dma_data", 32'(dma_out.data), exp_d.size() ? exp_d.pop_front() : -1);
    end
  end
  // Random plain-port traffic; bus pins stay inputs
  always @(posedge clock) begin
    gpio_out <= 8'(xs());
    gpio_oe <= 8'(xs()) & 8'hFC;
  end
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
  initial begin
    {n_fail, tests_run, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {gpio_out, gpio_oe} = '0;
    sys_rst = 1'b1;
    seed = 32'h9E524145;
    a0 = 7'(xs());
    a1 = a0 ^ 7'h15;
    foreach (bt[i]) bt[i] = 8'(xs());
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rd(da[i], dv[i], "reset_value");
    $display("test reset_values done");
    wr(OFS_ADDR0, 32'(a0));
    wr(OFS_ADDR1, 32'(a1));
    wr(OFS_CONFIG, 32'h3);
    wr(OFS_PTR, 32'h20000100);
    wr(OFS_LIMIT, 32'h2);
    wr(OFS_ENABLE, 32'h1);
    ptr = 32'h20000100;
    m.start();
    fork
      m.xfer({a0, 1'b0}, ack);
      held(OFS_ARM);
    join
    chk("addr_ack", 32'(ack), 32'h0);
    wr(OFS_PTR, 32'h30000000);
    wr(OFS_LIMIT, 32'h9);
    for (int i = 0; i < 3; i++) sendb(bt[i], i < 2);
    m.stop();
    ev(OFS_EV_WRITE, 32'h1);
    ev(OFS_EV_BEGUN, 32'h1);
    ev(OFS_EV_ERROR, 32'h1);
    ev(OFS_EV_STOPPED, 32'h1);
    rd(OFS_COUNT, 32'h2, "count");
    rd(OFS_MATCH, 32'h0, "match");
    $display("test limit_and_hold done");
    wr(OFS_ARM, 32'h1);
    ptr = 32'h30000000;
    m.start();
    m.xfer({a1, 1'b0}, ack);
    chk("addr1_ack", 32'(ack), 32'h0);
    sendb(bt[3], 1'b1);
    m.rstart();
    m.xfer({a0 ^ 7'h2A, 1'b0}, ack);
    chk("wrong_addr_ack", 32'(ack), 32'h1);
    m.stop();
    rd(OFS_MATCH, 32'h1, "match");
    rd(OFS_COUNT, 32'h1, "count");
    ev(OFS_EV_WRITE, 32'h1);
    wr(OFS_EV_STOPPED, 32'h0);
    wr(OFS_CONFIG, 32'h1);
    m.start();
    m.xfer({a1, 1'b0}, ack);
    chk("slot_off_ack", 32'(ack), 32'h1);
    m.stop();
    ev(OFS_EV_WRITE, 32'h0);
    $display("test match_and_restart done");
    wr(OFS_SHORTS, 32'h1);
    m.start();
    // The shortcut grabs the clock inside the answer bit, so resume there
    fork
      m.xfer({a0, 1'b1}, ack);
      held(OFS_RESUME);
    join
    chk("read_nack", 32'(ack), 32'h1);
    m.stop();
    chk("resumed", 32'(scl), 32'h1);
    ev(OFS_EV_READ, 32'h1);
    wr(OFS_SHORTS, 32'h0);
    wr(OFS_EV_STOPPED, 32'h0);
    $display("test suspend done");
    wr(OFS_ARM, 32'h1);
    // A new receive restarts at the latched pointer
    ptr = 32'h30000000;
    m.start();
    m.xfer({a0, 1'b0}, ack);
    sendb(bt[4], 1'b1);
    wr(OFS_STOP, 32'h1);
    ev(OFS_EV_STOPPED, 32'h1);
    m.stop();
    m.start();
    fork
      m.xfer({a0, 1'b0}, ack);
      held(OFS_STOP);
    join
    chk("after_stop_ack", 32'(ack), 32'h1);
    m.stop();
    ev(OFS_EV_STOPPED, 32'h1);
    wr(OFS_ENABLE, 32'h0);
    repeat (20) @(posedge clock);
    chk("dma_left", 32'(exp_a.size()), 32'h0);
    $display("test forced_stop done");
    end_sim();
  end
endmodule // twt_target_tb_top
